// file: src/rac_alarm_trim.sv
// Alarm compare, interrupt pin, load-cap trim and event output gating
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Event output off on battery when disabled
// - Pull-up disable bit forces pull-up off
// - Six-bit trim code drives both arrays
// - Trim code resets to zero, mid-scale
// - Battery adds selected capacitance delta
// - Rate trim changes counts per second
// - Low bits weigh 40 and 20 ppm
// - Rate trim shifts output except raw crystal
// - Alarm bytes: bit 7 compare enable
// - Match needs equality on enabled fields
// - Single mode: flag set, pin held low
// - Repeat mode pulses pin every match
// - Write 0 clears flag, or read auto-clears
// - Repeat pulses regardless of flag state
// - Repeat pulse active low, 250 ms
// - Frequency output overrides alarm on pin
module rac_alarm_trim
  import rac_pkg::*;
#(
  parameter int PULSE_TICKS = IRQ_PULSE_TICKS,
  parameter int TICKS_PER_SEC = OSC_HZ
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic osc_tick_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic reg_read_done_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [47:0] time_now_in,
  input wire logic on_battery_in,
  input wire logic event_detect_in,
  input wire logic pullup_schedule_in,
  output logic event_detect_output_out,
  output logic event_pullup_enable_out,
  output logic [5:0] cap_array_x1_out,
  output logic [5:0] cap_array_x2_out,
  output logic second_tick_out,
  output logic irq_frequency_output_n_out,
  output logic irq_frequency_output_oe_out
);
  initial begin
    if (PULSE_TICKS < 1 || PULSE_TICKS > 65535) begin
      $error("PULSE_TICKS out of range");
    end
  end
  logic auto_clear_on_read;
  logic alarm_flag;
  logic [7:0] int_ctl;
  logic [7:0] ev_ctl;
  logic [5:0] load_cap_trim_code;
  logic [1:0] battery_cap_delta;
  logic [2:0] digital_trim;
  logic [7:0] alarm_bytes [NUM_ALARM_FIELDS];
  logic [NUM_ALARM_FIELDS-1:0] field_ok;
  logic alarm_match;
  logic match_prev;
  logic match_rise;
  logic alarm_enable_bit;
  logic alarm_repeat_select;
  logic [3:0] frequency_output;
  logic frequency_output_active;
  logic single_done;
  logic [15:0] pulse_count;
  logic pulse_active;
  logic [19:0] div_count;
  logic trimmed_tick;
  logic status_read_pending;
  logic status_wr;
  logic flag_set;

  assign alarm_enable_bit = int_ctl[INT_ALARM_ENABLE_BIT];
  assign alarm_repeat_select = int_ctl[INT_REPEAT_BIT];
  assign frequency_output = int_ctl[3:0];
  assign frequency_output_active = frequency_output != FREQUENCY_OUTPUT_OFF;

  rac_rate_trim #(
    .TICKS_PER_SEC(TICKS_PER_SEC)
  ) u_trim (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .osc_tick_in(osc_tick_in),
    .digital_trim_in(digital_trim),
    .second_tick_out(second_tick_out),
    .trimmed_tick_out(trimmed_tick)
  );

  // Register writes
  assign status_wr = reg_write_in && reg_addr_in == STATUS_OFFSET;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      auto_clear_on_read <= 1'b0;
      int_ctl <= REG_RESET;
      ev_ctl <= REG_RESET;
      load_cap_trim_code <= LOAD_CAP_TRIM_RESET;
      battery_cap_delta <= DELTA_NONE;
      digital_trim <= 3'h0;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        STATUS_OFFSET: auto_clear_on_read <= reg_wdata_in[STATUS_AUTO_CLEAR_BIT];
        INTCTL_OFFSET: int_ctl <= reg_wdata_in;
        EVCTL_OFFSET: ev_ctl <= reg_wdata_in;
        ATR_OFFSET: begin
          load_cap_trim_code <= reg_wdata_in[5:0];
          battery_cap_delta <= reg_wdata_in[ATR_BATTERY_DELTA_LSB +: 2];
        end
        DTR_OFFSET: digital_trim <= reg_wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // Alarm bytes, one per field
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ALARM_FIELDS; gi++) begin : g_field
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          alarm_bytes[gi] <= REG_RESET;
        end else if (reg_write_in && reg_addr_in == ALARM_FIRST_OFFSET + 5'(gi)) begin
          alarm_bytes[gi] <= reg_wdata_in;
        end
      end
      // Disabled fields always agree
      assign field_ok[gi] = !alarm_bytes[gi][ALARM_ENABLE_FIELD_BIT] ||
        (alarm_bytes[gi][6:0] == time_now_in[gi*8 +: 7]);
    end
  endgenerate
  assign alarm_match = (|{alarm_bytes[0][7], alarm_bytes[1][7], alarm_bytes[2][7],
    alarm_bytes[3][7], alarm_bytes[4][7], alarm_bytes[5][7]}) && (&field_ok);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= alarm_match;
    end
  end
  assign match_rise = alarm_match && !match_prev && alarm_enable_bit && !frequency_output_active;
  assign flag_set = match_rise && !(single_done && !alarm_repeat_select);

  // Read data
  always_comb begin
    reg_rdata_out = 8'h00;
    case (reg_addr_in)
      STATUS_OFFSET: begin
        reg_rdata_out[STATUS_AUTO_CLEAR_BIT] = auto_clear_on_read;
        reg_rdata_out[STATUS_ALARM_FLAG_BIT] = alarm_flag;
      end
      INTCTL_OFFSET: reg_rdata_out = int_ctl;
      EVCTL_OFFSET: reg_rdata_out = ev_ctl;
      ATR_OFFSET: reg_rdata_out = {battery_cap_delta, load_cap_trim_code};
      DTR_OFFSET: reg_rdata_out = {5'h00, digital_trim};
      default: begin
        if (reg_addr_in >= ALARM_FIRST_OFFSET && reg_addr_in <= ALARM_LAST_OFFSET) begin
          reg_rdata_out = alarm_bytes[3'(reg_addr_in - ALARM_FIRST_OFFSET)];
        end
      end
    endcase
  end

  // Alarm flag: set wins over clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      status_read_pending <= 1'b0;
      alarm_flag <= 1'b0;
    end else begin
      if (reg_read_in && reg_addr_in == STATUS_OFFSET) begin
        status_read_pending <= 1'b1;
      end else if (reg_read_done_in) begin
        status_read_pending <= 1'b0;
      end
      if (flag_set) begin
        alarm_flag <= 1'b1;
      end else if (status_wr && !reg_wdata_in[STATUS_ALARM_FLAG_BIT]) begin
        alarm_flag <= 1'b0;
      end else if (reg_read_done_in && status_read_pending && auto_clear_on_read) begin
        alarm_flag <= 1'b0;
      end
    end
  end

  // Single mode matches once until re-armed
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      single_done <= 1'b0;
    end else if (reg_write_in && reg_addr_in == INTCTL_OFFSET) begin
      single_done <= 1'b0;
    end else if (match_rise && !alarm_repeat_select) begin
      single_done <= 1'b1;
    end
  end

  // Repeat pulse timer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pulse_count <= 16'h0000;
    end else if (match_rise && alarm_repeat_select) begin
      pulse_count <= 16'(PULSE_TICKS);
    end else if (osc_tick_in && pulse_count != 16'h0000) begin
      pulse_count <= pulse_count - 16'h0001;
    end
  end
  assign pulse_active = pulse_count != 16'h0000;

  // Frequency divider on the trimmed timebase
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      div_count <= 20'h0_0000;
    end else if (trimmed_tick) begin
      div_count <= div_count + 20'h0_0001;
    end
  end

  logic frequency_output_level;
  always_comb begin
    case (frequency_output)
      4'h2: frequency_output_level = div_count[2];
      4'h3: frequency_output_level = div_count[4];
      // Selections 4 to F halve per step, down to one cycle per 32 seconds
      default: frequency_output_level = div_count[5'(frequency_output) + 5'h04];
    endcase
  end

  // Pin drive: open-drain low, frequency overrides alarm
  logic pin_low;
  logic pin_disabled;
  assign pin_disabled = on_battery_in && int_ctl[INT_FREQUENCY_OUTPUT_BAT_DISABLE_BIT];
  always_comb begin
    if (frequency_output_active) begin
      if (frequency_output == FREQUENCY_OUTPUT_RAW) begin
        pin_low = !osc_tick_in;
      end else begin
        pin_low = !frequency_output_level;
      end
    end else if (alarm_repeat_select) begin
      pin_low = pulse_active;
    end else begin
      pin_low = alarm_flag && alarm_enable_bit;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_frequency_output_oe_out <= 1'b0;
    end else begin
      irq_frequency_output_oe_out <= pin_low && !pin_disabled;
    end
  end
  assign irq_frequency_output_n_out = 1'b0;

  // Event output and pull-up gating
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      event_detect_output_out <= 1'b0;
      event_pullup_enable_out <= 1'b0;
    end else begin
      event_detect_output_out <= event_detect_in &&
        !(on_battery_in && ev_ctl[EV_OUT_BAT_DISABLE_BIT]);
      event_pullup_enable_out <= !ev_ctl[EV_PULLUP_DISABLE_BIT] && pullup_schedule_in;
    end
  end

  // Capacitor code with battery delta, saturating
  logic [6:0] cap_sum;
  always_comb begin
    // Offset-binary view: top bit inverted so steps add linearly
    cap_sum = {1'b0, ~load_cap_trim_code[5], load_cap_trim_code[4:0]};
    if (on_battery_in) begin
      case (battery_cap_delta)
        DELTA_MINUS_HALF: cap_sum = (cap_sum == 7'h00) ? cap_sum : cap_sum - 7'h01;
        DELTA_PLUS_HALF: cap_sum = cap_sum + 7'h01;
        DELTA_PLUS_ONE: cap_sum = cap_sum + 7'h02;
        default: ;
      endcase
    end
    if (cap_sum > 7'h3F) begin
      cap_sum = 7'h3F;
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cap_array_x1_out <= LOAD_CAP_TRIM_RESET;
      cap_array_x2_out <= LOAD_CAP_TRIM_RESET;
    end else begin
      cap_array_x1_out <= {~cap_sum[5], cap_sum[4:0]};
      cap_array_x2_out <= {~cap_sum[5], cap_sum[4:0]};
    end
  end

  // Checks
  property p_single_pin;
    @(posedge clk_in) disable iff (sys_rst_in)
      (alarm_flag && alarm_enable_bit && !alarm_repeat_select && !frequency_output_active && !pin_disabled)
      |=> irq_frequency_output_oe_out;
  endproperty
  a_single_pin: assert property (p_single_pin) else $error("single alarm pin not low");
  property p_flag_set;
    @(posedge clk_in) disable iff (sys_rst_in) flag_set |=> alarm_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("alarm flag not set");
  property p_write_clear;
    @(posedge clk_in) disable iff (sys_rst_in)
      (status_wr && !reg_wdata_in[STATUS_ALARM_FLAG_BIT] && !flag_set) |=> !alarm_flag;
  endproperty
  a_write_clear: assert property (p_write_clear) else $error("flag not cleared by write");
  property p_pullup;
    @(posedge clk_in) disable iff (sys_rst_in) ev_ctl[EV_PULLUP_DISABLE_BIT] |=> !event_pullup_enable_out;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on while disabled");
  property p_evbat;
    @(posedge clk_in) disable iff (sys_rst_in)
      (on_battery_in && ev_ctl[EV_OUT_BAT_DISABLE_BIT]) |=> !event_detect_output_out;
  endproperty
  a_evbat: assert property (p_evbat) else $error("event output on in battery");
  property p_pulse_start;
    @(posedge clk_in) disable iff (sys_rst_in)
      (match_rise && alarm_repeat_select) |=> pulse_count == 16'(PULSE_TICKS);
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse not started");
  property p_cap_nobat;
    @(posedge clk_in) disable iff (sys_rst_in)
      !on_battery_in |=> cap_array_x1_out == $past(load_cap_trim_code);
  endproperty
  a_cap_nobat: assert property (p_cap_nobat) else $error("cap code mismatch");
  property p_frequency_output_override;
    @(posedge clk_in) disable iff (sys_rst_in)
      (frequency_output_active && !pin_disabled && frequency_output != FREQUENCY_OUTPUT_RAW) |=> irq_frequency_output_oe_out == !$past(frequency_output_level);
  endproperty
  a_frequency_output_override: assert property (p_frequency_output_override) else $error("frequency_output not driven");
  c_single: cover property (@(posedge clk_in) flag_set && !alarm_repeat_select);
  c_repeat: cover property (@(posedge clk_in) match_rise && alarm_repeat_select);
  c_autoclr: cover property (@(posedge clk_in) reg_read_done_in && status_read_pending && auto_clear_on_read);
endmodule
`default_nettype wire

// file: src/rac_pkg.sv
// Constants for the alarm, trim and event-output control block
package rac_pkg;
  // Register offsets on the internal register port
  localparam logic [4:0] STATUS_OFFSET = 5'h07;
  localparam logic [4:0] INTCTL_OFFSET = 5'h08;
  localparam logic [4:0] EVCTL_OFFSET = 5'h09;
  localparam logic [4:0] ATR_OFFSET = 5'h0A;
  localparam logic [4:0] DTR_OFFSET = 5'h0B;
  localparam logic [4:0] ALARM_FIRST_OFFSET = 5'h0C;
  localparam logic [4:0] ALARM_LAST_OFFSET = 5'h11;
  localparam int NUM_ALARM_FIELDS = 6;
  // Field positions
  localparam int STATUS_AUTO_CLEAR_BIT = 7;
  localparam int STATUS_ALARM_FLAG_BIT = 2;
  localparam int INT_REPEAT_BIT = 7;
  localparam int INT_ALARM_ENABLE_BIT = 6;
  localparam int INT_FREQUENCY_OUTPUT_BAT_DISABLE_BIT = 4;
  localparam int EV_OUT_BAT_DISABLE_BIT = 7;
  localparam int EV_PULLUP_DISABLE_BIT = 6;
  localparam int ATR_BATTERY_DELTA_LSB = 6;
  localparam int ALARM_ENABLE_FIELD_BIT = 7;
  localparam int DTR_SIGN_BIT = 2;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] LOAD_CAP_TRIM_RESET = 6'h00;
  // Battery delta encodings, in half-picofarad steps on the code
  localparam logic [1:0] DELTA_NONE = 2'h0;
  localparam logic [1:0] DELTA_MINUS_HALF = 2'h1;
  localparam logic [1:0] DELTA_PLUS_HALF = 2'h2;
  localparam logic [1:0] DELTA_PLUS_ONE = 2'h3;
  // Timebase: oscillator ticks per second, trim step per 20 ppm
  localparam int OSC_HZ = 32768;
  localparam int TICKS_PER_20PPM_STEP = 1;
  // Pulse length
  localparam int IRQ_PULSE_MS = 250;
  localparam int IRQ_PULSE_TICKS = (IRQ_PULSE_MS * OSC_HZ) / 1000;
  localparam logic [3:0] FREQUENCY_OUTPUT_OFF = 4'h0;
  localparam logic [3:0] FREQUENCY_OUTPUT_RAW = 4'h1;
endpackage

// file: src/rac_rate_trim.sv
// Seconds timebase with signed digital rate trim
`timescale 1ns/1ps
`default_nettype none
module rac_rate_trim
  import rac_pkg::*;
#(
  parameter int TICKS_PER_SEC = OSC_HZ
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic osc_tick_in,
  input wire logic [2:0] digital_trim_in,
  output logic second_tick_out,
  output logic trimmed_tick_out
);
  initial begin
    if (TICKS_PER_SEC < 16) begin
      $error("TICKS_PER_SEC too small");
    end
  end
  logic [16:0] count;
  logic [16:0] limit;
  logic [1:0] magnitude;
  logic [3:0] swallow;
  logic extra_tick;
  always_comb begin
    magnitude = digital_trim_in[1:0];
    // Slow down with sign 1 by adding counts, speed up by removing
    if (digital_trim_in[DTR_SIGN_BIT]) begin
      limit = 17'(TICKS_PER_SEC + TICKS_PER_20PPM_STEP * magnitude - 1);
    end else begin
      limit = 17'(TICKS_PER_SEC - TICKS_PER_20PPM_STEP * magnitude - 1);
    end
  end
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count <= 17'h0_0000;
    end else if (osc_tick_in) begin
      if (count >= limit) begin
        count <= 17'h0_0000;
      end else begin
        count <= count + 17'h0_0001;
      end
    end
  end
  assign second_tick_out = osc_tick_in && (count >= limit);
  // Trimmed tick for divided outputs: a full second always holds TICKS_PER_SEC ticks
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      swallow <= 4'h0;
      extra_tick <= 1'b0;
    end else begin
      extra_tick <= osc_tick_in && !digital_trim_in[DTR_SIGN_BIT] && swallow != 4'h0;
      if (second_tick_out) begin
        swallow <= 4'({2'h0, magnitude});
      end else if (osc_tick_in && swallow != 4'h0) begin
        swallow <= swallow - 4'h1;
      end
    end
  end
  // Slow-down drops a tick, speed-up adds one on the clock after an oscillator tick
  assign trimmed_tick_out = (osc_tick_in && !(digital_trim_in[DTR_SIGN_BIT] && swallow != 4'h0)) || extra_tick;
endmodule
`default_nettype wire

// file: verification/rac_host_model.sv
// Host model driving the block's internal register port
`timescale 1ns/1ps
`default_nettype none
module rac_host_model
  import rac_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [4:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic reg_read_done_out
);
  int idle_cycles;

  initial begin
    idle_cycles = 0;
    reg_addr_out = 5'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    reg_read_done_out = 1'b0;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    repeat (idle_cycles) @(posedge clk_in);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_write_out <= 1'b1;
    @(posedge clk_in);
    reg_write_out <= 1'b0;
    // Released data does not keep showing the last byte
    reg_wdata_out <= ~d;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    repeat (idle_cycles) @(posedge clk_in);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_read_out <= 1'b1;
    @(posedge clk_in);
    d = reg_rdata_in;
    reg_read_out <= 1'b0;
    reg_read_done_out <= 1'b1;
    @(posedge clk_in);
    reg_read_done_out <= 1'b0;
  endtask

  task automatic clear_flag();
    wr(STATUS_OFFSET, 8'h00);
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the alarm, trim and event-output block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rac_pkg::*;
  localparam int PT = 4;
  localparam int TPS = 64;
  logic clk_in, sys_rst_in, osc_tick_in, wr, rd, rd_done, on_bat, ev_in, sched, ev_out, pu_out, sec, irq_n, oe, prev;
  logic [1:0] div;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, d, v;
  logic [47:0] now;
  logic [5:0] cx1, cx2, code;
  logic [15:0] exp_q[$], obs_q[$];
  int err_count, samples_checked, cycles, n, e;
  integer seed;

  rac_host_model host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wdata_out(wdata),
    .reg_write_out(wr), .reg_read_out(rd), .reg_read_done_out(rd_done));
  rac_alarm_trim #(.PULSE_TICKS(PT), .TICKS_PER_SEC(TPS)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .osc_tick_in(osc_tick_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_read_done_in(rd_done), .reg_rdata_out(rdata), .time_now_in(now), .on_battery_in(on_bat),
    .event_detect_in(ev_in), .pullup_schedule_in(sched), .event_detect_output_out(ev_out),
    .event_pullup_enable_out(pu_out), .cap_array_x1_out(cx1), .cap_array_x2_out(cx2), .second_tick_out(sec),
    .irq_frequency_output_n_out(irq_n), .irq_frequency_output_oe_out(oe));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Oscillator tick every fourth clock, and hang guard
  always @(posedge clk_in) begin
    div <= div + 2'h1;
    osc_tick_in <= (div == 2'h3);
    cycles++;
    if (cycles == 50000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic note(input logic [15:0] seen, input logic [15:0] expv);
    obs_q.push_back(seen);
    exp_q.push_back(expv);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  initial forever begin
    wait (obs_q.size() > 0);
    check(obs_q.pop_front(), exp_q.pop_front());
  end

  task automatic finish_test();
    #1;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Battery code: linear cap index is code with top bit inverted
  function automatic logic [5:0] bat_code(input logic [5:0] c, input logic [1:0] dl);
    int lin;
    lin = int'(c ^ 6'h20);
    if (dl == DELTA_MINUS_HALF) lin = lin - 1;
    if (dl == DELTA_PLUS_HALF) lin = lin + 1;
    if (dl == DELTA_PLUS_ONE) lin = lin + 2;
    if (lin < 0) lin = 0;
    if (lin > 63) lin = 63;
    return 6'(lin) ^ 6'h20;
  endfunction

  task automatic sec_gap(output int g);
    g = 0;
    while (sec !== 1'b1 && g < 2000) begin
      @(posedge clk_in);
      g++;
    end
    g = 0;
    do begin
      @(posedge clk_in);
      g++;
    end while (sec !== 1'b1 && g < 2000);
  endtask

  task automatic pulse_len(output int g);
    int w;
    w = 0;
    g = 0;
    while (oe !== 1'b1 && w < 20) begin
      @(posedge clk_in);
      w++;
    end
    while (oe === 1'b1 && g < 200) begin
      @(posedge clk_in);
      g++;
    end
  endtask

  initial begin
    seed = 32'h12e9_a8d8;
    sys_rst_in = 1'b1;
    osc_tick_in = 1'b0;
    on_bat = 1'b0;
    ev_in = 1'b0;
    sched = 1'b0;
    div = 2'h0;
    now = 48'h0000_0000_0000;
    cycles = 0;
    err_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int a = 7; a < 18; a++) begin
      host.rd(5'(a), d);
      note({8'h00, d}, {8'h00, REG_RESET});
    end
    host.wr(5'h1f, 8'hff);
    host.rd(5'h1f, d);
    note({8'h00, d}, 16'h0000);
    note({4'h0, cx1, cx2}, {4'h0, LOAD_CAP_TRIM_RESET, LOAD_CAP_TRIM_RESET});
    note({15'h0000, irq_n}, 16'h0000);
    for (int i = 0; i < NUM_ALARM_FIELDS; i++) begin
      v = 8'($random(seed));
      host.wr(ALARM_FIRST_OFFSET + 5'(i), v);
      host.rd(ALARM_FIRST_OFFSET + 5'(i), d);
      note({8'h00, d}, {8'h00, v});
    end
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      code = (k == 1) ? 6'h20 : 6'($random(seed));
      host.wr(ATR_OFFSET, {2'(k), code});
      on_bat <= 1'b0;
      repeat (3) @(posedge clk_in);
      note({4'h0, cx1, cx2}, {4'h0, code, code});
      on_bat <= 1'b1;
      repeat (3) @(posedge clk_in);
      note({4'h0, cx1, cx2}, {4'h0, bat_code(code, 2'(k)), bat_code(code, 2'(k))});
    end
    $display("test cap trim done");
    host.idle_cycles = 2;
    for (int i = 0; i < 16; i++) begin
      host.wr(EVCTL_OFFSET, {i[3], i[2], 6'h00});
      on_bat <= i[1];
      ev_in <= i[0];
      sched <= 1'($random(seed));
      repeat (3) @(posedge clk_in);
      note({15'h0000, ev_out}, {15'h0000, i[0] & ~(i[1] & i[3])});
      note({15'h0000, pu_out}, {15'h0000, sched & ~i[2]});
    end
    host.idle_cycles = 0;
    on_bat <= 1'b0;
    $display("test event gating done");
    for (int t = 0; t < 8; t++) begin
      host.wr(DTR_OFFSET, {5'h00, 3'(t)});
      sec_gap(n);
      sec_gap(n);
      sec_gap(n);
      e = 4 * (TPS + (t[2] ? int'(t[1:0]) : -int'(t[1:0])));
      note(16'(n), 16'(e));
    end
    $display("test rate trim done");
    now <= 48'h0000_0000_0530;
    host.wr(ALARM_FIRST_OFFSET, 8'hb0);
    host.wr(ALARM_FIRST_OFFSET + 5'h01, 8'h87);
    for (int i = 2; i < NUM_ALARM_FIELDS; i++) host.wr(ALARM_FIRST_OFFSET + 5'(i), 8'h00);
    host.wr(INTCTL_OFFSET, 8'h40);
    repeat (4) @(posedge clk_in);
    note({15'h0000, oe}, 16'h0000);
    host.wr(ALARM_FIRST_OFFSET + 5'h01, 8'h07);
    repeat (4) @(posedge clk_in);
    note({15'h0000, oe}, 16'h0001);
    now <= 48'h0000_0000_0531;
    repeat (4) @(posedge clk_in);
    note({15'h0000, oe}, 16'h0001);
    host.rd(STATUS_OFFSET, d);
    note({15'h0000, d[STATUS_ALARM_FLAG_BIT]}, 16'h0001);
    host.clear_flag();
    repeat (3) @(posedge clk_in);
    note({15'h0000, oe}, 16'h0000);
    host.wr(STATUS_OFFSET, 8'h80);
    host.wr(INTCTL_OFFSET, 8'h40);
    now <= 48'h0000_0000_0530;
    repeat (4) @(posedge clk_in);
    note({15'h0000, oe}, 16'h0001);
    host.rd(STATUS_OFFSET, d);
    note({15'h0000, d[STATUS_ALARM_FLAG_BIT]}, 16'h0001);
    repeat (3) @(posedge clk_in);
    note({15'h0000, oe}, 16'h0000);
    host.rd(STATUS_OFFSET, d);
    note({15'h0000, d[STATUS_ALARM_FLAG_BIT]}, 16'h0000);
    host.wr(STATUS_OFFSET, 8'h00);
    $display("test single alarm done");
    now <= 48'h0000_0000_0531;
    host.wr(INTCTL_OFFSET, 8'hc0);
    for (int p = 0; p < 2; p++) begin
      now <= 48'h0000_0000_0530;
      pulse_len(n);
      note({15'h0000, n >= 12 && n <= 20}, 16'h0001);
      host.rd(STATUS_OFFSET, d);
      note({15'h0000, d[STATUS_ALARM_FLAG_BIT]}, 16'h0001);
      now <= 48'h0000_0000_0531;
      repeat (2) @(posedge clk_in);
    end
    $display("test repeat alarm done");
    host.wr(INTCTL_OFFSET, {4'hc, FREQUENCY_OUTPUT_RAW});
    now <= 48'h0000_0000_0530;
    n = 0;
    prev = oe;
    repeat (64) begin
      @(posedge clk_in);
      if (oe !== prev) n++;
      prev = oe;
    end
    note({15'h0000, n >= 8}, 16'h0001);
    for (int t = 3; t < 8; t += 4) begin
      host.wr(DTR_OFFSET, {5'h00, 3'(t)});
      host.wr(INTCTL_OFFSET, 8'h02);
      sec_gap(n);
      n = 0;
      e = 0;
      prev = oe;
      do begin
        @(posedge clk_in);
        if (oe !== prev) n++;
        prev = oe;
        if (sec === 1'b1) e++;
      end while (e < 2 && n < 100);
      note(16'(n), 16'(2 * TPS / 4));
    end
    host.wr(INTCTL_OFFSET, {4'h0, FREQUENCY_OUTPUT_OFF});
    repeat (4) @(posedge clk_in);
    note({15'h0000, oe}, 16'h0000);
    $display("test frequency output done");
    finish_test();
  end
endmodule
`default_nettype wire
